// [rtl/spg_gpio_top.v]
// Shared-pin GPIO port: APB register file, pin synchronisers and pin drivers.
// Assumes an APB master on pclk and pins from outside the clock domain.
//
// Function
// [R1] Share mode 0 makes every shared pin an individual GPIO pin.
// [R2] Share mode 1 hands the pins to memory and host functions.
// [R3] Pin indexes: address 3..0, data 19..4, control 20..35, host 36..45.
// [R4] Three register sets of three: output enable, direction, data.
// [R5] Each enable bit turns that pin's output driver on or off.
// [R6] Enable and direction both 1: pin driven from its data bit.
// [R7] Enable and direction both 0: data bit reads the pin level.
// [R8] Share mode overrides all enable bits.
// [R9] Enable 0: pin never drives, input only.
// [R10] Software keeps enable and direction equal; otherwise output undefined.
// [R11] Direction 1: data bit drives pin; direction 0: data mirrors pin.
// [R12] Data registers hold values read from or written to the pins.
// [R13] First enable register at 0x4400, bits 15..0, reset 0.
// [R14] First direction register at 0x4401, reset 0, pins start as inputs.
// [R15] First data register at 0x4402, one bit per pin 0..15.
// [R16] After reset each data bit takes its pin's level.
// [R17] Disabled or memory/host pins leave the GPIO driver off.
// [R18] Pin inputs are synchronised before reaching the data register.
//
// Our own choice: the APB register port.
`include "spg_gpio_map.vh"

module spg_gpio_top #(
  parameter NPIN            = `SPG_PINS,
  parameter [0:0] MODE_RST  = `SPG_MODE_RST
) (
  input  wire                    pclk,
  input  wire                    presetn,
  input  wire                    psel,
  input  wire                    penable,
  input  wire                    pwrite,
  input  wire [`SPG_ADDR_W-1:0]  paddr,
  input  wire [31:0]             pwdata,
  input  wire [3:0]              pstrb,
  output reg  [31:0]             prdata,
  output reg                     pready,
  output reg                     pslverr,
  input  wire [NPIN-1:0]         shared_pin_io_in,
  output wire [NPIN-1:0]         shared_pin_io_out,
  output wire [NPIN-1:0]         shared_pin_io_oe,
  input  wire [NPIN-1:0]         alt_func_out,
  input  wire [NPIN-1:0]         alt_func_oe,
  output reg  [NPIN-1:0]         alt_func_in,
  output reg                     share_mode
);

  localparam FW = `SPG_FLAT_W;
  localparam RW = `SPG_REG_W;

  // ***********************************************************************
  // Helper functions
  // ***********************************************************************

  // Byte-lane merge of a 16-bit register; lanes 2 and 3 carry nothing
  function [RW-1:0] spg_merge;
    input [RW-1:0] old_val;
    input [31:0]   wdata;
    input [3:0]    strb;
    begin
      spg_merge[7:0]  = strb[0] ? wdata[7:0]  : old_val[7:0];
      spg_merge[15:8] = strb[1] ? wdata[15:8] : old_val[15:8];
    end
  endfunction

  // Register index to set number (0..2) and kind (0 en, 1 dir, 2 dat, 3 sel)
  function [4:0] spg_decode;
    input [15:0] idx;
    begin
      case (idx)
        `SPG_IDX_EN0:     spg_decode = 5'b1_00_00;
        `SPG_IDX_DIR0:    spg_decode = 5'b1_00_01;
        `SPG_IDX_DAT0:    spg_decode = 5'b1_00_10;
        `SPG_IDX_EN1:     spg_decode = 5'b1_01_00;
        `SPG_IDX_DIR1:    spg_decode = 5'b1_01_01;
        `SPG_IDX_DAT1:    spg_decode = 5'b1_01_10;
        `SPG_IDX_EN2:     spg_decode = 5'b1_10_00;
        `SPG_IDX_DIR2:    spg_decode = 5'b1_10_01;
        `SPG_IDX_DAT2:    spg_decode = 5'b1_10_10;
        `SPG_IDX_BUS_SEL: spg_decode = 5'b1_00_11;
        default:          spg_decode = 5'b0_00_00;
      endcase
    end
  endfunction

  // ***********************************************************************
  // Pin input synchronisers
  // ***********************************************************************

  wire [NPIN-1:0] pin_sync;
  wire [FW-1:0]   pin_flat;
  wire [FW-1:0]   valid_mask;

  // Pins reach the data register only after two flops
  spg_sync #(
    .W (NPIN)
  ) u_sync (
    .clk   (pclk),
    .rst_n (presetn),
    .d_in  (shared_pin_io_in),
    .q_out (pin_sync) // [R18]
  );

  assign pin_flat   = {{(FW-NPIN){1'b0}}, pin_sync};
  assign valid_mask = {{(FW-NPIN){1'b0}}, {NPIN{1'b1}}};

  // ***********************************************************************
  // Register state
  // ***********************************************************************

  reg  [FW-1:0] en_reg;
  reg  [FW-1:0] en_next;
  reg  [FW-1:0] dir_reg;
  reg  [FW-1:0] dir_next;
  reg  [FW-1:0] dat_reg;
  reg  [FW-1:0] dat_next;
  reg           mode_reg;
  reg           mode_next;

  // ***********************************************************************
  // APB decode
  // ***********************************************************************

  wire [4:0] dec;
  wire       dec_hit;
  wire [1:0] dec_set;
  wire [1:0] dec_kind;
  wire       setup_phase;
  wire       wr_go;

  assign dec      = spg_decode(paddr[`SPG_ADDR_W-1:2]);
  assign dec_hit  = dec[4];
  assign dec_set  = dec[3:2];
  assign dec_kind = dec[1:0];

  assign setup_phase = psel & ~penable;
  // A write lands only on the completing edge of a mapped access
  assign wr_go = psel & penable & pready & pwrite & ~pslverr;

  // ***********************************************************************
  // Next-state of the register sets
  // ***********************************************************************

  integer k;
  integer b;
  reg [RW-1:0] cur_word;

  always @* begin
    en_next   = en_reg;
    dir_next  = dir_reg;
    dat_next  = dat_reg;
    mode_next = mode_reg;
    cur_word  = {RW{1'b0}};
    for (k = 0; k < `SPG_SETS; k = k + 1) begin // [R4]
      if (wr_go && dec_set == k[1:0] && dec_kind == 2'd0) begin
        en_next[k*RW +: RW] = spg_merge(en_reg[k*RW +: RW], pwdata, pstrb); // [R5] [R13]
      end
      if (wr_go && dec_set == k[1:0] && dec_kind == 2'd1) begin
        dir_next[k*RW +: RW] = spg_merge(dir_reg[k*RW +: RW], pwdata, pstrb); // [R14]
      end
      cur_word = dat_reg[k*RW +: RW];
      if (wr_go && dec_set == k[1:0] && dec_kind == 2'd2) begin
        cur_word = spg_merge(dat_reg[k*RW +: RW], pwdata, pstrb); // [R12] [R15]
      end
      dat_next[k*RW +: RW] = cur_word;
    end
    // Input bits follow the pin; a write to them is lost on purpose
    for (b = 0; b < FW; b = b + 1) begin
      if (!dir_reg[b]) begin
        dat_next[b] = pin_flat[b]; // [R7] [R11] [R16]
      end
    end
    if (wr_go && dec_set == 2'd0 && dec_kind == 2'd3 && pstrb[0]) begin
      mode_next = pwdata[`SPG_BUS_SEL_MODE]; // [R1] [R2]
    end
    // Pins beyond NPIN do not exist
    en_next  = en_next & valid_mask;
    dir_next = dir_next & valid_mask;
    dat_next = dat_next & valid_mask;
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      en_reg   <= {`SPG_EN_RST, `SPG_EN_RST, `SPG_EN_RST}; // [R13]
      dir_reg  <= {`SPG_DIR_RST, `SPG_DIR_RST, `SPG_DIR_RST}; // [R14]
      // Constant under reset; pin level is loaded on the third edge after release
      dat_reg  <= {FW{1'b0}}; // [R16]
      mode_reg <= MODE_RST;
    end else begin
      en_reg   <= en_next;
      dir_reg  <= dir_next;
      dat_reg  <= dat_next;
      mode_reg <= mode_next;
    end
  end

  // ***********************************************************************
  // APB answer
  // ***********************************************************************

  reg [RW-1:0] rd_word;
  reg          rd_err;

  always @* begin
    rd_word = {RW{1'b0}};
    rd_err  = ~dec_hit;
    case (dec_kind)
      2'd0:    rd_word = en_reg[dec_set*RW +: RW];
      2'd1:    rd_word = dir_reg[dec_set*RW +: RW];
      2'd2:    rd_word = dat_reg[dec_set*RW +: RW]; // [R12]
      2'd3:    rd_word = {{(RW-1){1'b0}}, mode_reg};
      default: rd_word = {RW{1'b0}};
    endcase
    if (!dec_hit) begin
      rd_word = {RW{1'b0}};
    end
  end

  // No wait cycle: answer is prepared during setup, ready in the first access cycle
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h0000_0000;
    end else begin
      pready <= setup_phase;
      if (setup_phase) begin
        pslverr <= rd_err;
        prdata  <= pwrite ? 32'h0000_0000 : {16'h0000, rd_word};
      end else if (!psel) begin
        pslverr <= 1'b0;
        prdata  <= 32'h0000_0000;
      end
    end
  end

  // ***********************************************************************
  // Pin side
  // ***********************************************************************

  // Vector index n is shared pin n; the pad ring follows the fixed mapping
  spg_pin_drive #(
    .W (NPIN)
  ) u_drive (
    .clk        (pclk),
    .rst_n      (presetn),
    .share_mode (mode_reg), // [R8]
    .gp_en      (en_reg[NPIN-1:0]), // [R3] [R6] [R9]
    .gp_dir     (dir_reg[NPIN-1:0]), // [R10]
    .gp_dat     (dat_reg[NPIN-1:0]),
    .alt_out    (alt_func_out),
    .alt_oe     (alt_func_oe),
    .pin_out    (shared_pin_io_out),
    .pin_oe     (shared_pin_io_oe) // [R17]
  );

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      alt_func_in <= {NPIN{1'b0}};
      share_mode  <= MODE_RST;
    end else begin
      alt_func_in <= pin_sync;
      share_mode  <= mode_reg;
    end
  end

endmodule // spg_gpio_top

// [rtl/spg_gpio_map.vh]
// Register indexes, field positions and reset values of the shared-pin GPIO port.
// Assumes it is included by bare name from the rtl/ modules; definitions only.
`ifndef SPG_GPIO_MAP_VH
`define SPG_GPIO_MAP_VH

// ***********************************************************************
// Register indexes (byte address is four times the index)
// ***********************************************************************
`define SPG_IDX_EN0        16'h4400
`define SPG_IDX_DIR0       16'h4401
`define SPG_IDX_DAT0       16'h4402
`define SPG_IDX_EN1        16'h4403
`define SPG_IDX_DIR1       16'h4404
`define SPG_IDX_DAT1       16'h4405
`define SPG_IDX_EN2        16'h4406
`define SPG_IDX_DIR2       16'h4407
`define SPG_IDX_DAT2       16'h4408
`define SPG_IDX_BUS_SEL    16'h4410

// ***********************************************************************
// Field positions and widths
// ***********************************************************************
`define SPG_ADDR_W         18
`define SPG_REG_W          16
`define SPG_SETS           3
`define SPG_FLAT_W         48
`define SPG_PINS           46
`define SPG_BUS_SEL_MODE   0

// ***********************************************************************
// Reset values and mode codes
// ***********************************************************************
`define SPG_EN_RST         16'h0000
`define SPG_DIR_RST        16'h0000
`define SPG_MODE_GPIO      1'b0
`define SPG_MODE_FULL      1'b1
`define SPG_MODE_RST       1'b0
`define SPG_SYNC_RST       1'b0

`endif

// [rtl/spg_sync.v]
// Two-flop synchroniser for a bundle of independent pin levels.
// Assumes each bit is a slow level; no multi-bit coherence is promised.
`include "spg_gpio_map.vh"

module spg_sync #(
  parameter W = 46
) (
  input  wire         clk,
  input  wire         rst_n,
  input  wire [W-1:0] d_in,
  output reg  [W-1:0] q_out
);

  reg [W-1:0] meta_reg;

  // First stage feeds only the second stage
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      meta_reg <= {W{`SPG_SYNC_RST}};
      q_out    <= {W{`SPG_SYNC_RST}};
    end else begin
      meta_reg <= d_in;
      q_out    <= meta_reg;
    end
  end

endmodule // spg_sync

// [rtl/spg_pin_drive.v]
// Registered output stage for the shared pins: GPIO or memory/host function.
// Assumes the memory/host logic supplies its own drive and enable per pin.
`include "spg_gpio_map.vh"

module spg_pin_drive #(
  parameter W = 46
) (
  input  wire         clk,
  input  wire         rst_n,
  input  wire         share_mode,
  input  wire [W-1:0] gp_en,
  input  wire [W-1:0] gp_dir,
  input  wire [W-1:0] gp_dat,
  input  wire [W-1:0] alt_out,
  input  wire [W-1:0] alt_oe,
  output reg  [W-1:0] pin_out,
  output reg  [W-1:0] pin_oe
);

  reg [W-1:0] out_next;
  reg [W-1:0] oe_next;

  always @* begin
    if (share_mode == `SPG_MODE_FULL) begin
      // Share mode wins over every enable bit
      out_next = alt_out; // [R2]
      oe_next  = alt_oe; // [R8]
    end else begin
      // Enable alone opens the driver; disabled pins float
      oe_next  = gp_en; // [R5] [R9] [R17]
      // Enable without direction drives low: avoids echoing the pin back
      out_next = gp_dat & gp_dir & gp_en; // [R6] [R11]
    end
  end

  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pin_out <= {W{1'b0}};
      pin_oe  <= {W{1'b0}};
    end else begin
      pin_out <= out_next;
      pin_oe  <= oe_next;
    end
  end

endmodule // spg_pin_drive

// [tb/spg_gpio_props.sv]
// Concurrent checks on the shared-pin GPIO port top.
// Assumes pclk with async active-low presetn.
module spg_gpio_props #(
  parameter NPIN = 46
) (
  input wire logic            pclk,
  input wire logic            presetn,
  input wire logic            psel,
  input wire logic            penable,
  input wire logic            pwrite,
  input wire logic [17:0]     paddr,
  input wire logic [31:0]     prdata,
  input wire logic            pready,
  input wire logic            pslverr,
  input wire logic [NPIN-1:0] shared_pin_io_in,
  input wire logic [NPIN-1:0] shared_pin_io_out,
  input wire logic [NPIN-1:0] shared_pin_io_oe,
  input wire logic [NPIN-1:0] alt_func_out,
  input wire logic [NPIN-1:0] alt_func_oe,
  input wire logic [NPIN-1:0] alt_func_in,
  input wire logic            share_mode
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  // ***********************
  // Helpers
  // ***********************
  logic [2:0]  up_cnt_reg;
  logic [15:0] idx;
  logic        unmapped;
  assign idx = paddr[17:2];
  assign unmapped = !(idx >= 16'h4400 && idx <= 16'h4408) && idx != 16'h4410;
  // Sync flops hold reset values for the first edges
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn)
      up_cnt_reg <= 3'h0;
    else if (up_cnt_reg != 3'h4)
      up_cnt_reg <= up_cnt_reg + 3'h1;
  end
  sequence setup_s;
    psel && !penable;
  endsequence
  sequence full_s;
    share_mode [*3];
  endsequence
  sequence gpio_s;
    !share_mode [*3];
  endsequence
  // ***********************
  // Assertions
  // ***********************
  a_pready_access: assert property (setup_s |=> pready) else $error("no ready after setup");
  a_pready_single: assert property (pready |=> !pready) else $error("ready too long");
  a_unmapped_err: assert property (setup_s ##0 unmapped |=> pslverr) else $error("no error");
  a_mapped_ok: assert property (setup_s ##0 !unmapped |=> !pslverr) else $error("bad error");
  a_err_read_zero: assert property (pready && pslverr && !pwrite |-> prdata == '0) else $error("err data");
  a_high_half: assert property (pready |-> prdata[31:16] == 16'h0000) else $error("upper half set");
  a_full_oe: assert property (full_s |-> shared_pin_io_oe == $past(alt_func_oe)) else $error("oe mux");
  a_full_out: assert property (full_s |-> shared_pin_io_out == $past(alt_func_out)) else $error("out mux");
  a_gpio_no_drive: assert property (gpio_s |-> (shared_pin_io_out & ~shared_pin_io_oe) == '0)
    else $error("undriven pin high");
  a_sync_lat: assert property (up_cnt_reg == 3'h4 |-> alt_func_in == $past(shared_pin_io_in, 3))
    else $error("sync latency");
endmodule // spg_gpio_props

bind spg_gpio_top spg_gpio_props #(.NPIN(NPIN)) spg_gpio_props_inst (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
  .prdata(prdata), .pready(pready), .pslverr(pslverr), .shared_pin_io_in(shared_pin_io_in),
  .shared_pin_io_out(shared_pin_io_out), .shared_pin_io_oe(shared_pin_io_oe), .alt_func_out(alt_func_out),
  .alt_func_oe(alt_func_oe), .alt_func_in(alt_func_in), .share_mode(share_mode));

// [tb/spg_pin_model.sv]
// External world on the shared pins: each pin shows its driver or an outside level.
// Assumes no pull resistors; an undriven pin follows what the bench applies.
module spg_pin_model #(
  parameter NPIN = 46
) (
  input wire logic [NPIN-1:0]  pin_out,
  input wire logic [NPIN-1:0]  pin_oe,
  input wire logic [NPIN-1:0]  ext_level,
  output wire logic [NPIN-1:0] pin_level
);
  timeunit 1ns;
  timeprecision 1ps;
  assign pin_level = (pin_oe & pin_out) | (~pin_oe & ext_level);
endmodule // spg_pin_model

// [tb/shared_pin_gpio_port_bench.sv]
// Self-checking bench for the shared-pin GPIO port over APB.
// Assumes the design answers each setup with one access cycle.
module shared_pin_gpio_port_bench;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int NPIN = 46;
  logic            pclk = 1'b0;
  logic            presetn = 1'b0;
  logic            psel = 1'b0;
  logic            penable = 1'b0;
  logic            pwrite = 1'b0;
  logic [17:0]     paddr = '0;
  logic [31:0]     pwdata = '0;
  logic [3:0]      pstrb = 4'h0;
  logic [NPIN-1:0] ext_level;
  logic [NPIN-1:0] alt_out;
  logic [NPIN-1:0] alt_oe;
  wire  [31:0]     prdata;
  wire             pready;
  wire             pslverr;
  wire             share_mode;
  wire  [NPIN-1:0] pin_out;
  wire  [NPIN-1:0] pin_oe;
  wire  [NPIN-1:0] pin_level;
  wire  [NPIN-1:0] alt_in;
  logic [33:0]     exp_q[$];
  logic [33:0]     e;
  logic [15:0]     v;
  logic [15:0]     d;
  logic [15:0]     m;
  logic [15:0]     v0;
  logic [15:0]     d0;
  int              seed = 2;
  int              error_cnt = 0;
  int              comparisons = 0;

  spg_gpio_top spg_gpio_top_inst (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .shared_pin_io_in(pin_level), .shared_pin_io_out(pin_out), .shared_pin_io_oe(pin_oe),
    .alt_func_out(alt_out), .alt_func_oe(alt_oe), .alt_func_in(alt_in), .share_mode(share_mode));
  spg_pin_model spg_pin_model_inst (.pin_out(pin_out), .pin_oe(pin_oe), .ext_level(ext_level),
    .pin_level(pin_level));

  always #5 pclk = ~pclk;

  task automatic chk(input logic [47:0] got, input logic [47:0] exp);
    comparisons++;
    if (got !== exp) begin
      error_cnt++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // Expected note is {write, error, data}
  task automatic apb(input logic wr, input logic [15:0] idx, input logic [31:0] wd, input logic [32:0] ex);
    int n;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= {idx, 2'b00};
    pwdata <= wd;
    pstrb <= 4'hf;
    exp_q.push_back({wr, ex});
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    // Ready is judged only at rising edges, before this edge's updates
    @(posedge pclk);
    while (pready !== 1'b1 && n < 20) begin
      n++;
      @(posedge pclk);
    end
    if (pready !== 1'b1) begin
      error_cnt++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, pready, 1'b1);
    end
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  // Values seen here are those before this edge's updates
  always @(posedge pclk) begin
    if (psel && penable && pready === 1'b1) begin
      e = exp_q.pop_front();
      chk({15'h0, pslverr, pwrite ? 32'h0 : prdata}, {15'h0, e[32], e[33] ? 32'h0 : e[31:0]});
    end
  end

  task automatic close_out();
    $display("errors=%0d comparisons=%0d", error_cnt, comparisons);
    if (error_cnt == 0 && comparisons > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  initial begin
    repeat (5000) @(posedge pclk);
    error_cnt++;
    close_out();
  end

  initial begin
    ext_level = NPIN'({$random(seed), $random(seed)});
    alt_out = '0;
    alt_oe = '0;
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    repeat (4) @(posedge pclk);
    apb(1'b0, 16'h4400, '0, '0);
    apb(1'b0, 16'h4401, '0, '0);
    apb(1'b0, 16'h4402, '0, {17'h0, ext_level[15:0]});
    for (int k = 0; k < 3; k++) begin
      v = $random(seed);
      d = $random(seed);
      m = (k == 2) ? 16'h3fff : 16'hffff;
      if (k == 0) begin
        v0 = v;
        d0 = d;
      end
      apb(1'b1, 16'(16'h4400 + 3 * k), {16'h0, v}, '0);
      apb(1'b1, 16'(16'h4401 + 3 * k), {16'h0, v}, '0);
      apb(1'b1, 16'(16'h4402 + 3 * k), {16'h0, d}, '0);
      apb(1'b0, 16'(16'h4400 + 3 * k), '0, {17'h0, v & m});
      apb(1'b0, 16'(16'h4401 + 3 * k), '0, {17'h0, v & m});
      apb(1'b0, 16'(16'h4402 + 3 * k), '0, {17'h0, ((d & v) | ({2'b00, ext_level} >> (16 * k)) & ~v) & m});
      repeat (2) @(posedge pclk);
      chk({2'b00, pin_oe} >> (16 * k) & 48'hffff, {32'h0, v & m});
      chk({2'b00, pin_out} >> (16 * k) & 48'hffff, {32'h0, d & v & m});
    end
    ext_level <= NPIN'({$random(seed), $random(seed)});
    repeat (5) @(posedge pclk);
    chk({2'b00, alt_in}, {2'b00, pin_level});
    apb(1'b0, 16'h4402, '0, {17'h0, (d0 & v0) | (ext_level[15:0] & ~v0)});
    apb(1'b0, 16'h4409, '0, {1'b1, 32'h0});
    apb(1'b1, 16'h440f, 32'hffff_ffff, {1'b1, 32'h0});
    alt_out <= NPIN'({$random(seed), $random(seed)});
    alt_oe <= NPIN'({$random(seed), $random(seed)});
    apb(1'b1, 16'h4410, 32'h1, '0);
    apb(1'b0, 16'h4410, '0, 33'h1);
    repeat (3) @(posedge pclk);
    chk({2'b00, pin_oe}, {2'b00, alt_oe});
    chk({2'b00, pin_out}, {2'b00, alt_out});
    chk({47'h0, share_mode}, 48'h1);
    apb(1'b1, 16'h4410, '0, '0);
    repeat (3) @(posedge pclk);
    chk({32'h0, pin_oe[15:0]}, {32'h0, v0});
    chk({32'h0, pin_out[15:0]}, {32'h0, d0 & v0});
    chk({47'h0, share_mode}, 48'h0);
    close_out();
  end
endmodule // shared_pin_gpio_port_bench
